// *** verilog/fwl_consts.vh ***
`ifndef FWL_CONSTS_VH
`define FWL_CONSTS_VH
// Opcodes, one byte each; a four-line command carries the same byte
`define FWL_OP_WR_SET      8'h06
`define FWL_OP_WR_CLR      8'h04
// Opcode clock counts per frame, single-line and four-line
`define FWL_OPCLK_SINGLE   4'h8
`define FWL_OPCLK_QUAD     4'h2
// Security flags register bit positions
`define FWL_SEC_PMS        7
`define FWL_SEC_EFAIL      6
`define FWL_SEC_PFAIL      5
`define FWL_SEC_ESUSP      3
`define FWL_SEC_PSUSP      2
`define FWL_SEC_LOCK       1
`define FWL_SEC_FACT       0
// Dummy-cycle select reset code and the count it gives
`define FWL_DSEL_RESET     2'b00
`define FWL_DUMMY_RESET    4'ha
// Operation kinds reported by the array engine
`define FWL_KIND_W         3
`define FWL_KIND_PROG      3'd0
`define FWL_KIND_ERASE     3'd1
`define FWL_KIND_SUSPEND   3'd2
`define FWL_KIND_RESUME    3'd3
`define FWL_KIND_SECWRITE  3'd4
`define FWL_KIND_OTHERWEL  3'd5
// Read types for dummy count lookup
`define FWL_RD_OUT         2'd0
`define FWL_RD_DUAL        2'd1
`define FWL_RD_QUAD        2'd2
`endif

// *** verilog/fwl_opcode_rx.v ***
`timescale 1ns/100ps
`include "fwl_consts.vh"
// Shifts in one opcode per frame and flags a clean one-opcode frame at
// chip-select rise. Pins arrive already synchronised.
module fwl_opcode_rx (
  input  wire       clk_i,
  input  wire       rst_n_i,
  input  wire       cs_n_i,
  input  wire       sclk_i,
  input  wire [3:0] io_i,
  input  wire       quad_i,
  output reg        done_o,
  output reg  [7:0] op_o
);
  reg       sclk_q;
  reg       cs_q;
  reg [7:0] sh_q;
  reg [3:0] cnt_q;
  wire      rise = sclk_i & ~sclk_q;
  wire [3:0] need = quad_i ? `FWL_OPCLK_QUAD : `FWL_OPCLK_SINGLE;

  ////////////////////////////////////////////////////////////////////////
  // Count edges; upper lines ignored in single-line mode
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_q <= 1'b0;
      cs_q   <= 1'b1;
      sh_q   <= 8'h00;
      cnt_q  <= 4'h0;
      done_o <= 1'b0;
      op_o   <= 8'h00;
    end else begin
      sclk_q <= sclk_i;
      cs_q   <= cs_n_i;
      done_o <= 1'b0;
      if (cs_n_i) begin
        // Only an exact opcode length counts; longer frames are dropped
        if (!cs_q && cnt_q == need) begin // RULE21
          done_o <= 1'b1;
          op_o   <= sh_q;
        end
        cnt_q <= 4'h0;
      end else if (rise) begin
        if (quad_i)
          sh_q <= {sh_q[3:0], io_i}; // RULE14
        else
          sh_q <= {sh_q[6:0], io_i[0]}; // RULE14
        if (cnt_q != 4'hf)
          cnt_q <= cnt_q + 4'h1; // Saturates so long frames stay invalid
      end
    end
  end
endmodule // fwl_opcode_rx

// *** verilog/fwl_latch_security.v ***
`timescale 1ns/100ps
`include "fwl_consts.vh"
// How it works
// RULE1: Dummy code picks count per read type
// RULE2: Erase fail sets flag; good erase clears
// RULE3: Program fail sets flag; good program clears
// RULE4: Erase suspend sets flag; resume clears it
// RULE5: Program suspend sets flag; resume clears it
// RULE6: Factory lock indicator is read-only bit0
// RULE7: Lockdown bit set once, then OTP frozen
// RULE8: Secured OTP mode blocks main array access
// RULE9: Security register bit layout, volatile zero default
// RULE10: Protect mode bit is one-time, default zero
// RULE11: Write enable command sets latch
// RULE12: Host enables writes before each change; dummy select and OTP writes here need no latch
// RULE13: Write enable frame is opcode only
// RULE14: Eight single or two quad opcode clocks
// RULE15: Write disable command clears latch
// RULE16: Write disable frame is opcode only
// RULE17: Reset and completions clear the latch; a resume completion here leaves it set
// RULE18: Latch low means program/erase ignored
// RULE19: Protected target ignored, latch cleared
// RULE20: New dummy code applies at next read
// RULE21: Only clean single-opcode frames decode
module fwl_latch_security #(
  parameter       FACTORY_LOCK = 1'b0, // Arbitrary strap value
  parameter [1:0] DSEL_RESET   = `FWL_DSEL_RESET
) (
  input  wire       CLK_I,
  input  wire       RSTN_I,
  input  wire       HW_RESET_N_I,
  input  wire       CS_N_I,
  input  wire       SCLK_I,
  input  wire [3:0] IO_I,
  input  wire       QUAD_MODE_I,
  // Array engine requests and completions
  input  wire       OP_REQ_I,
  input  wire       OP_PROTECTED_I,
  input  wire       OP_DONE_I,
  input  wire [2:0] OP_KIND_I,
  input  wire       OP_FAIL_I,
  input  wire       SEC_LOCK_REQ_I,
  input  wire       SEC_PMS_REQ_I,
  input  wire       OTP_WRITE_REQ_I,
  input  wire       OTP_MODE_I,
  input  wire       DSEL_WR_I,
  input  wire [1:0] DSEL_VAL_I,
  input  wire       READ_START_I,
  input  wire [1:0] READ_TYPE_I,
  output reg        OP_ACCEPT_O,
  output reg        OTP_WRITE_OK_O,
  output reg        ARRAY_ALLOW_O,
  output reg        WR_LATCH_O,
  output reg  [7:0] SEC_REG_O,
  output reg  [3:0] DUMMY_CYCLES_O
);
  // Reset release and pin synchronisers
  reg        rst_a_q;
  reg        rst_b_q;
  reg  [1:0] hw_s_q;
  reg  [1:0] cs_s_q;
  reg  [1:0] sc_s_q;
  reg  [3:0] io_a_q;
  reg  [3:0] io_b_q;
  wire       rst_n = rst_b_q;

  always @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rst_a_q <= 1'b0;
      rst_b_q <= 1'b0;
    end else begin
      rst_a_q <= 1'b1;
      rst_b_q <= rst_a_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Two flops on every pin; first stage feeds only the second
  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      hw_s_q <= 2'b11;
      cs_s_q <= 2'b11;
      sc_s_q <= 2'b00;
      io_a_q <= 4'h0;
      io_b_q <= 4'h0;
    end else begin
      hw_s_q <= {hw_s_q[0], HW_RESET_N_I};
      cs_s_q <= {cs_s_q[0], CS_N_I};
      sc_s_q <= {sc_s_q[0], SCLK_I};
      io_a_q <= IO_I;
      io_b_q <= io_a_q;
    end
  end

  wire       op_done;
  wire [7:0] op_code;

  fwl_opcode_rx u_rx (
    .clk_i   (CLK_I),
    .rst_n_i (rst_n),
    .cs_n_i  (cs_s_q[1]),
    .sclk_i  (sc_s_q[1]),
    .io_i    (io_b_q),
    .quad_i  (QUAD_MODE_I),
    .done_o  (op_done),
    .op_o    (op_code)
  );

  ////////////////////////////////////////////////////////////////////////
  // Dummy count lookup, shared by every read type
  function [3:0] dummy_count;
    input [1:0] sel;
    input [1:0] rt;
    begin
      case (rt)
        `FWL_RD_DUAL: dummy_count = (sel == 2'b11) ? 4'h4 :
                                    (sel == 2'b10) ? 4'h6 :
                                    (sel == 2'b01) ? 4'h8 : 4'ha;
        `FWL_RD_QUAD: dummy_count = (sel == 2'b11) ? 4'h6 :
                                    (sel == 2'b10) ? 4'h4 :
                                    (sel == 2'b01) ? 4'h8 : 4'ha;
        default:      dummy_count = (sel == 2'b11) ? 4'h8 :
                                    (sel == 2'b10) ? 4'h6 :
                                    (sel == 2'b01) ? 4'h8 : 4'ha;
      endcase
    end
  endfunction

  reg [1:0] dsel_q;
  reg       wlat_q;
  reg       efail_q;
  reg       pfail_q;
  reg       esusp_q;
  reg       psusp_q;
  reg       lock_q;
  reg       pms_q;
  reg       fact_q;

  wire hw_rst  = ~hw_s_q[1];
  wire done_p  = OP_DONE_I && OP_KIND_I == `FWL_KIND_PROG;
  wire done_e  = OP_DONE_I && OP_KIND_I == `FWL_KIND_ERASE;
  // Every completion but a resume drops the latch
  wire wlat_clr = (OP_DONE_I && OP_KIND_I != `FWL_KIND_RESUME) ||
                  (OP_REQ_I && (OP_PROTECTED_I || !wlat_q));

  ////////////////////////////////////////////////////////////////////////
  // Write enable latch; a request in the set cycle sees the old value
  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      wlat_q <= 1'b0; // RULE17
    end else if (hw_rst) begin
      wlat_q <= 1'b0; // RULE17
    end else if (op_done && op_code == `FWL_OP_WR_SET) begin
      wlat_q <= 1'b1; // RULE11
    end else if (op_done && op_code == `FWL_OP_WR_CLR) begin
      wlat_q <= 1'b0; // RULE15
    end else if (wlat_clr) begin
      wlat_q <= 1'b0; // RULE17 RULE19
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status flags; failure only reports, never stops the engine
  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      efail_q <= 1'b0;
      pfail_q <= 1'b0;
      esusp_q <= 1'b0;
      psusp_q <= 1'b0;
    end else begin
      if (OP_REQ_I && OP_PROTECTED_I && wlat_q && OP_KIND_I ==
          `FWL_KIND_ERASE)
        efail_q <= 1'b1; // RULE2
      else if (done_e)
        efail_q <= OP_FAIL_I; // RULE2
      if (OP_REQ_I && OP_PROTECTED_I && wlat_q && OP_KIND_I ==
          `FWL_KIND_PROG)
        pfail_q <= 1'b1; // RULE3
      else if (done_p)
        pfail_q <= OP_FAIL_I; // RULE3
      // Suspend kind: the engine reports which operation was paused
      if (OP_DONE_I && OP_KIND_I == `FWL_KIND_SUSPEND) begin
        if (OP_FAIL_I)
          psusp_q <= 1'b1; // RULE5
        else
          esusp_q <= 1'b1; // RULE4
      end else if (OP_DONE_I && OP_KIND_I == `FWL_KIND_RESUME) begin
        esusp_q <= 1'b0; // RULE4
        psusp_q <= 1'b0; // RULE5
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // One-time lock and PMS bits: once set they stay set until reset clears them; dummy select stays rewritable
  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      lock_q <= 1'b0;
      pms_q  <= 1'b0; // RULE10
      fact_q <= 1'b0;
      dsel_q <= DSEL_RESET;
    end else begin
      fact_q <= FACTORY_LOCK; // RULE6
      if (SEC_LOCK_REQ_I && wlat_q && !lock_q)
        lock_q <= 1'b1; // RULE7
      if (SEC_PMS_REQ_I && wlat_q)
        pms_q <= 1'b1; // RULE10
      if (DSEL_WR_I)
        dsel_q <= DSEL_VAL_I;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs; dummy count latched at read start
  always @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      OP_ACCEPT_O    <= 1'b0;
      OTP_WRITE_OK_O <= 1'b0;
      ARRAY_ALLOW_O  <= 1'b0;
      WR_LATCH_O     <= 1'b0;
      SEC_REG_O      <= 8'h00;
      DUMMY_CYCLES_O <= `FWL_DUMMY_RESET;
    end else begin
      OP_ACCEPT_O    <= OP_REQ_I && wlat_q && !OP_PROTECTED_I
                        && !OTP_MODE_I; // RULE18 RULE19 RULE8
      OTP_WRITE_OK_O <= OTP_WRITE_REQ_I && !lock_q && !fact_q
                        && OTP_MODE_I; // RULE7
      ARRAY_ALLOW_O  <= !OTP_MODE_I; // RULE8
      WR_LATCH_O     <= wlat_q;
      SEC_REG_O      <= {pms_q, efail_q, pfail_q, 1'b0, esusp_q,
                         psusp_q, lock_q, fact_q}; // RULE9
      if (READ_START_I)
        DUMMY_CYCLES_O <= dummy_count(dsel_q, READ_TYPE_I); // RULE1 RULE20
    end
  end
endmodule // fwl_latch_security

// *** tb/fwl_host_model.sv ***
`timescale 1ns/100ps
// Host side: one opcode-only frame; clock parked low outside frames
module fwl_host_model (
  output logic       cs_n_o,
  output logic       sclk_o,
  output logic [3:0] io_o
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    io_o = 4'h5;
  end
  // Upper lines toggle in single-line mode; the device must ignore them
  task send(input [7:0] op, input q, input integer n);
    integer i;
    begin
      cs_n_o = 1'b0;
      for (i = 0; i < n; i = i + 1) begin
        io_o = q ? op[7-4*(i%2) -: 4] : {~io_o[3:1], op[7-(i%8)]};
        #24 sclk_o = 1'b1;
        #24 sclk_o = 1'b0;
      end
      #24 cs_n_o = 1'b1;
      io_o = ~io_o; // Released lines must not keep stale data
    end
  endtask
endmodule // fwl_host_model

// *** tb/fwl_latch_security_assertions.sv ***
`timescale 1ns/100ps
`include "fwl_consts.vh"
// Watches the top ports only
module fwl_latch_security_assertions #(parameter FACTORY_LOCK = 1'b0) (
  input wire logic       CLK_I,
  input wire logic       RSTN_I,
  input wire logic       OTP_MODE_I,
  input wire logic       OP_REQ_I,
  input wire logic       OP_PROTECTED_I,
  input wire logic       OP_DONE_I,
  input wire logic       OP_FAIL_I,
  input wire logic       OTP_WRITE_REQ_I,
  input wire logic [2:0] OP_KIND_I,
  input wire logic       OP_ACCEPT_O,
  input wire logic       OTP_WRITE_OK_O,
  input wire logic       ARRAY_ALLOW_O,
  input wire logic       WR_LATCH_O,
  input wire logic [7:0] SEC_REG_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  sequence s_done(k, f);
    OP_DONE_I && OP_KIND_I == k && OP_FAIL_I == f;
  endsequence
  property p_wlat_clr;
    OP_DONE_I && OP_KIND_I != `FWL_KIND_RESUME |-> ##[1:6] !WR_LATCH_O;
  endproperty
  // The latch output lags the internal latch by one cycle
  property p_no_wlat;
    OP_REQ_I ##1 !WR_LATCH_O |-> !OP_ACCEPT_O;
  endproperty
  property p_prot;
    OP_REQ_I && OP_PROTECTED_I |=> !OP_ACCEPT_O ##1 !WR_LATCH_O;
  endproperty
  // Skips the reset synchroniser's release cycles
  property p_array;
    $past(RSTN_I, 5) |-> ARRAY_ALLOW_O == !$past(OTP_MODE_I);
  endproperty
  property p_ro;
    SEC_REG_O[4] == 1'b0 && SEC_REG_O[0] == FACTORY_LOCK;
  endproperty
  property p_lock;
    SEC_REG_O[1] && OTP_WRITE_REQ_I |=> !OTP_WRITE_OK_O [*2] and SEC_REG_O[1];
  endproperty
  property p_efail;
    s_done(`FWL_KIND_ERASE, 1'b1) |-> ##[1:4] SEC_REG_O[6];
  endproperty
  property p_psusp;
    s_done(`FWL_KIND_SUSPEND, 1'b1) |-> ##[1:4] SEC_REG_O[2];
  endproperty
  a_wlat_clr: assert property (p_wlat_clr) else $error("latch kept");
  a_no_wlat: assert property (p_no_wlat) else $error("accepted");
  a_prot: assert property (p_prot) else $error("protected");
  a_array: assert property (p_array) else $error("array gate");
  a_ro: assert property (p_ro) else $error("fixed bits");
  a_lock: assert property (p_lock) else $error("lockdown");
  a_efail: assert property (p_efail) else $error("erase flag");
  a_psusp: assert property (p_psusp) else $error("suspend flag");
endmodule // fwl_latch_security_assertions
bind fwl_latch_security fwl_latch_security_assertions
  #(.FACTORY_LOCK(FACTORY_LOCK)) u_chk (.*);

// *** tb/fwl_latch_security_tb.sv ***
`timescale 1ns/100ps
`include "fwl_consts.vh"
module fwl_latch_security_tb;
  reg clk = 0, rstn = 0, hw_n = 1, quad = 0, req = 0, prot = 0, done = 0;
  reg fail = 0, lk = 0, pm = 0, ow = 0, om = 0, dcw = 0, rs = 0;
  reg  [2:0] kind = 0;
  reg  [1:0] dcv = 0, rt = 0;
  reg  [3:0] last = 4'ha;
  wire       cs_n, sclk, acc, ok, arr, wlat;
  wire [3:0] io, dum;
  wire [7:0] sec;
  integer n_errors = 0, checked = 0, n_acc = 0, n_ok = 0, c, t;
  // Dummy counts by read type and code, nibble (type*4+code)
  localparam [47:0] DCT = 48'h648a_468a_868a;
  fwl_host_model host (.cs_n_o(cs_n), .sclk_o(sclk), .io_o(io));
  fwl_latch_security uut (.CLK_I(clk), .RSTN_I(rstn), .HW_RESET_N_I(hw_n),
    .CS_N_I(cs_n), .SCLK_I(sclk), .IO_I(io), .QUAD_MODE_I(quad),
    .OP_REQ_I(req), .OP_PROTECTED_I(prot), .OP_DONE_I(done),
    .OP_KIND_I(kind), .OP_FAIL_I(fail), .SEC_LOCK_REQ_I(lk),
    .SEC_PMS_REQ_I(pm), .OTP_WRITE_REQ_I(ow), .OTP_MODE_I(om),
    .DSEL_WR_I(dcw), .DSEL_VAL_I(dcv), .READ_START_I(rs), .READ_TYPE_I(rt),
    .OP_ACCEPT_O(acc), .OTP_WRITE_OK_O(ok), .ARRAY_ALLOW_O(arr),
    .WR_LATCH_O(wlat), .SEC_REG_O(sec), .DUMMY_CYCLES_O(dum));
  always #2.5 clk = ~clk;
  // One-cycle pulses are counted mid-cycle, clear of the launching edge
  always @(negedge clk) begin
    if (acc === 1'b1) n_acc = n_acc + 1;
    if (ok === 1'b1) n_ok = n_ok + 1;
  end
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task hit(input [6:0] m);
    begin
      @(negedge clk) {rs, dcw, ow, pm, lk, done, req} = m;
      @(negedge clk) {rs, dcw, ow, pm, lk, done, req} = 7'h00;
      cyc(4);
    end
  endtask
  task frm(input [7:0] op, input q, input integer n);
    begin
      @(negedge clk) quad = q;
      host.send(op, q, n);
      cyc(10);
    end
  endtask
  task opd(input [2:0] k, input f, input [7:0] exp);
    begin
      kind = k;
      fail = f;
      hit(7'h02);
      chk(sec, exp);
    end
  endtask
  task print_verdict;
    begin
      if (n_errors == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  initial begin
    #100000;
    n_errors = n_errors + 1;
    print_verdict;
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(8);
    rstn = 1'b1;
    cyc(4);
    chk(sec, 8'h00);
    chk({3'h0, wlat, dum}, 8'h0a);
    frm(`FWL_OP_WR_SET, 1'b0, 8);
    chk(8'(wlat), 8'h1);
    frm(`FWL_OP_WR_CLR, 1'b0, 8);
    chk(8'(wlat), 8'h0);
    frm(`FWL_OP_WR_SET, 1'b1, 2);
    chk(8'(wlat), 8'h1);
    frm(`FWL_OP_WR_CLR, 1'b0, 7);
    chk(8'(wlat), 8'h1);
    frm(`FWL_OP_WR_CLR, 1'b1, 3);
    chk(8'(wlat), 8'h1);
    prot = 1'b1;
    hit(7'h01);
    chk({sec[6:0], wlat}, 8'h40);
    prot = 1'b0;
    hit(7'h01);
    frm(`FWL_OP_WR_SET, 1'b1, 2);
    hit(7'h01);
    chk(8'(n_acc), 8'h1);
    opd(`FWL_KIND_PROG, 1'b0, 8'h00);
    opd(`FWL_KIND_ERASE, 1'b1, 8'h40);
    opd(`FWL_KIND_ERASE, 1'b0, 8'h00);
    opd(`FWL_KIND_SUSPEND, 1'b1, 8'h04);
    opd(`FWL_KIND_RESUME, 1'b0, 8'h00);
    opd(`FWL_KIND_SUSPEND, 1'b0, 8'h08);
    opd(`FWL_KIND_RESUME, 1'b0, 8'h00);
    for (c = 0; c < 4; c = c + 1)
      for (t = 0; t < 3; t = t + 1) begin
        dcv = c[1:0];
        hit(7'h20);
        chk(8'(dum), 8'(last));
        rt = t[1:0];
        hit(7'h40);
        last = DCT[(t*4+c)*4 +: 4];
        chk(8'(dum), 8'(last));
      end
    om = 1'b1;
    cyc(3);
    chk(8'(arr), 8'h0);
    om = 1'b0;
    frm(`FWL_OP_WR_SET, 1'b0, 8);
    hit(7'h08);
    chk(sec, 8'h80);
    om = 1'b1;
    hit(7'h10);
    chk(8'(n_ok), 8'h1);
    frm(`FWL_OP_WR_SET, 1'b0, 8);
    hit(7'h04);
    hit(7'h10);
    chk(8'(n_ok), 8'h1);
    hit(7'h01);
    chk(8'(n_acc), 8'h1);
    om = 1'b0;
    cyc(2);
    chk({sec[7:1], arr}, 8'h83);
    frm(`FWL_OP_WR_SET, 1'b0, 8);
    chk(8'(wlat), 8'h1);
    hw_n = 1'b0;
    cyc(4);
    hw_n = 1'b1;
    cyc(4);
    chk(8'(wlat), 8'h0);
    print_verdict;
  end
endmodule // fwl_latch_security_tb
